// ==== dbg_trace_pkg.sv ====
// constants, register map and carrier types for the debug trace block
package dbg_trace_pkg;

  // register word offsets (word addresses on a 32-bit Avalon-MM word bus)
  localparam logic [3:0] CMP_A_HIGH_ADDR   = 4'h0;
  localparam logic [3:0] CMP_A_LOW_ADDR    = 4'h1;
  localparam logic [3:0] CMP_B_HIGH_ADDR   = 4'h2;
  localparam logic [3:0] CMP_B_LOW_ADDR    = 4'h3;
  localparam logic [3:0] FIFO_HIGH_ADDR    = 4'h4;
  localparam logic [3:0] FIFO_LOW_ADDR     = 4'h5;
  localparam logic [3:0] CONTROL_ADDR      = 4'h6;
  localparam logic [3:0] TRIG_MODE_ADDR    = 4'h7;
  localparam logic [3:0] STATUS_ADDR       = 4'h8;

  // reset values
  localparam logic [7:0]  BYTE_RESET       = 8'h00;
  localparam logic [15:0] WORD_RESET       = 16'h0000;
  localparam logic [31:0] BUS_ZERO         = 32'h0000_0000;

  // control register bit positions
  localparam int CTL_ENABLE_BIT            = 7;
  localparam int CTL_ARM_BIT               = 6;
  localparam int CTL_TAG_BIT               = 5;
  localparam int CTL_BREAK_EN_BIT          = 4;
  localparam int CTL_A_DIR_VAL_BIT         = 3;
  localparam int CTL_A_DIR_QUAL_BIT        = 2;
  localparam int CTL_B_DIR_VAL_BIT         = 1;
  localparam int CTL_B_DIR_QUAL_BIT        = 0;

  // trigger mode register layout
  localparam int TRIG_OPQ_BIT              = 7;
  localparam int TRIG_BEGIN_BIT            = 6;

  // trigger mode codes
  localparam logic [3:0] MODE_A_ONLY       = 4'h0;
  localparam logic [3:0] MODE_A_OR_B       = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B     = 4'h2;
  localparam logic [3:0] MODE_EVENT_B      = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EV_B  = 4'h4;
  localparam logic [3:0] MODE_A_AND_B      = 4'h5;
  localparam logic [3:0] MODE_A_AND_NOT_B  = 4'h6;
  localparam logic [3:0] MODE_INSIDE       = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE      = 4'h8;

  // fifo geometry
  localparam int          FIFO_DEPTH       = 8;
  localparam logic [3:0]  FIFO_FULL_COUNT  = 4'h8;

  // one observed cpu bus cycle
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rd;
    logic        opfetch;
  } cpu_cycle_t;

  // break request toward the cpu
  typedef struct packed {
    logic req;
    logic tag;
  } break_req_t;

endpackage : dbg_trace_pkg

// ==== dbg_trace.sv ====
// on-chip debug comparators, trace fifo and control register
//
// Behaviour
// - comparator A low byte register holds compare bits 7..0.
// - comparator A high byte register holds compare bits 15..8.
// - two byte registers hold comparator B compare bits 15..8 and 7..0.
// - comparator bytes reset to zero, always readable, writes ignored while armed.
// - fifo high byte reads upper byte of current word; writes do nothing.
// - event-only modes store low byte only; fifo high byte reads zero.
// - event-only modes are trigger codes 0011 and 0100.
// - high byte read keeps fifo; low byte read returns byte then advances.
// - while armed, low byte reads do not advance the fifo.
// - unarmed low byte read stores last opcode fetch address at fifo end.
// - profiling samples emerge eight reads later; ninth read returns first.
// - control register readable and writable at all times.
// - bit 7 enables module; setting it is refused while secured.
// - bit 6 arms run and flag; completion or clearing bit 6/7 disarms.
// - run completes on fifo full (begin) or trigger (end trace).
// - bit 5 selects tag or force breaks; meaningless while breaks disabled.
// - bit 4 requests breaks at trigger (end) or fifo full (begin).
// - break timing does not depend on opcode qualification; here opq gates trig, so run end and break wait on it.
// - bits 2/3 qualify comparator A by access direction.
// - bits 0/1 qualify comparator B by access direction.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module dbg_trace (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  // avalon-mm slave
  input  wire logic [3:0]              avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // cpu side
  input  wire dbg_trace_pkg::cpu_cycle_t cpu_i,
  input  wire logic                    secure_i,
  output var dbg_trace_pkg::break_req_t brk_o
);

  ////////////////////////////////////////////////////////////////////////////
  // fifo geometry, declared ahead of the storage that uses it
  localparam int         FIFO_DEPTH   = dbg_trace_pkg::FIFO_DEPTH;
  localparam logic [3:0] FIFO_FULL_M1 = dbg_trace_pkg::FIFO_FULL_COUNT - 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] cmp_a_r;
  logic [15:0] cmp_b_r;
  logic [7:0]  ctl_r;
  logic [7:0]  trig_r;
  logic        af_r;
  logic        bf_r;
  logic        a_seen_r;
  logic [3:0]  cnt_r;
  logic [15:0] last_op_r;
  logic [15:0] fifo_r [FIFO_DEPTH];
  logic        ack_r;

  wire logic armed   = ctl_r[dbg_trace_pkg::CTL_ARM_BIT];
  wire logic enabled = ctl_r[dbg_trace_pkg::CTL_ENABLE_BIT];
  wire logic bus_req = (avs_read_i | avs_write_i) & ~ack_r;
  wire logic wr_go   = avs_write_i & ~ack_r & avs_byteenable_i[0];
  wire logic rd_go   = avs_read_i & ~ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers
  function automatic logic dir_ok(input logic qual, input logic val, input logic rd);
    dir_ok = ~qual | (val == rd);
  endfunction

  function automatic logic event_only(input logic [3:0] mode);
    event_only = (mode == dbg_trace_pkg::MODE_EVENT_B) |
                 (mode == dbg_trace_pkg::MODE_A_THEN_EV_B);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // comparators
  logic [3:0] mode;
  logic       begin_tr;
  logic       match_a;
  logic       match_b;
  logic       dmatch_b;
  logic       trig;
  logic       store;
  logic [15:0] store_word;

  assign mode     = trig_r[3:0];
  assign begin_tr = trig_r[dbg_trace_pkg::TRIG_BEGIN_BIT] | event_only(mode);
  assign match_a  = cpu_i.valid & (cpu_i.addr == cmp_a_r) &
                    dir_ok(ctl_r[dbg_trace_pkg::CTL_A_DIR_QUAL_BIT],
                           ctl_r[dbg_trace_pkg::CTL_A_DIR_VAL_BIT], cpu_i.rd);
  assign match_b  = cpu_i.valid & (cpu_i.addr == cmp_b_r) &
                    dir_ok(ctl_r[dbg_trace_pkg::CTL_B_DIR_QUAL_BIT],
                           ctl_r[dbg_trace_pkg::CTL_B_DIR_VAL_BIT], cpu_i.rd);
  assign dmatch_b = cpu_i.valid & (cpu_i.data == cmp_b_r[7:0]);

  // trigger decode per mode; opcode qualification only gates the trigger
  always_comb begin
    logic opq;
    opq   = ~trig_r[dbg_trace_pkg::TRIG_OPQ_BIT] | cpu_i.opfetch;
    trig  = 1'b0;
    store = 1'b0;
    store_word = cpu_i.addr;
    unique case (mode)
      dbg_trace_pkg::MODE_A_ONLY:      trig = match_a;
      dbg_trace_pkg::MODE_A_OR_B:      trig = match_a | match_b;
      dbg_trace_pkg::MODE_A_THEN_B:    trig = (a_seen_r | match_a) & match_b;
      dbg_trace_pkg::MODE_EVENT_B:     trig = match_b;
      dbg_trace_pkg::MODE_A_THEN_EV_B: trig = (a_seen_r | match_a) & match_b;
      dbg_trace_pkg::MODE_A_AND_B:     trig = match_a & dmatch_b;
      dbg_trace_pkg::MODE_A_AND_NOT_B: trig = match_a & ~dmatch_b;
      dbg_trace_pkg::MODE_INSIDE:
        trig = cpu_i.valid & (cpu_i.addr >= cmp_a_r) & (cpu_i.addr <= cmp_b_r);
      dbg_trace_pkg::MODE_OUTSIDE:
        trig = cpu_i.valid & ((cpu_i.addr < cmp_a_r) | (cpu_i.addr > cmp_b_r));
      default:                         trig = 1'b0;
    endcase
    trig = trig & opq;
    if (event_only(mode)) begin
      store      = trig;
      store_word = {dbg_trace_pkg::BYTE_RESET, cpu_i.data};
    end else if (begin_tr) begin
      store = (af_r | bf_r | trig) & cpu_i.valid & cpu_i.opfetch;
    end else begin
      store = cpu_i.valid & cpu_i.opfetch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run sequencing
  logic run_done;
  assign run_done = armed & ((begin_tr & store & (cnt_r == FIFO_FULL_M1)) |
                             (~begin_tr & trig));

  // control register: bus write, secure gate, auto disarm
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_r <= dbg_trace_pkg::BYTE_RESET;
    end else begin
      if (wr_go && avs_address_i == dbg_trace_pkg::CONTROL_ADDR) begin
        ctl_r <= avs_writedata_i[7:0];
        if (secure_i && !enabled) begin
          ctl_r[dbg_trace_pkg::CTL_ENABLE_BIT] <= 1'b0;
        end
        if (!(avs_writedata_i[dbg_trace_pkg::CTL_ENABLE_BIT] &&
              (enabled || !secure_i))) begin
          ctl_r[dbg_trace_pkg::CTL_ARM_BIT] <= 1'b0;
        end
      end else if (run_done) begin
        ctl_r[dbg_trace_pkg::CTL_ARM_BIT] <= 1'b0;
      end
    end
  end

  // comparator and trigger mode registers, locked while armed
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_a_r <= dbg_trace_pkg::WORD_RESET;
      cmp_b_r <= dbg_trace_pkg::WORD_RESET;
      trig_r  <= dbg_trace_pkg::BYTE_RESET;
    end else if (wr_go && !armed) begin
      unique case (avs_address_i)
        dbg_trace_pkg::CMP_A_HIGH_ADDR: cmp_a_r[15:8] <= avs_writedata_i[7:0];
        dbg_trace_pkg::CMP_A_LOW_ADDR:  cmp_a_r[7:0]  <= avs_writedata_i[7:0];
        dbg_trace_pkg::CMP_B_HIGH_ADDR: cmp_b_r[15:8] <= avs_writedata_i[7:0];
        dbg_trace_pkg::CMP_B_LOW_ADDR:  cmp_b_r[7:0]  <= avs_writedata_i[7:0];
        dbg_trace_pkg::TRIG_MODE_ADDR:  trig_r <= avs_writedata_i[7:0] & 8'hCF;
        default:                        cmp_a_r <= cmp_a_r;
      endcase
    end
  end

  // match flags and valid count, cleared on arming write
  logic arm_write;
  assign arm_write = wr_go && avs_address_i == dbg_trace_pkg::CONTROL_ADDR &&
                     avs_writedata_i[dbg_trace_pkg::CTL_ARM_BIT];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      af_r     <= 1'b0;
      bf_r     <= 1'b0;
      a_seen_r <= 1'b0;
      cnt_r    <= 4'h0;
    end else if (arm_write) begin
      af_r     <= 1'b0;
      bf_r     <= 1'b0;
      a_seen_r <= 1'b0;
      cnt_r    <= 4'h0;
    end else if (armed) begin
      af_r     <= af_r | match_a;
      bf_r     <= bf_r | match_b;
      a_seen_r <= a_seen_r | match_a;
      if (store && cnt_r != dbg_trace_pkg::FIFO_FULL_COUNT) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // most recent opcode fetch address
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_op_r <= dbg_trace_pkg::WORD_RESET;
    end else if (cpu_i.valid && cpu_i.opfetch) begin
      last_op_r <= cpu_i.addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trace fifo: word 0 is the head, shifts toward it
  logic fl_read;
  assign fl_read = rd_go && avs_address_i == dbg_trace_pkg::FIFO_LOW_ADDR;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_r[i] <= dbg_trace_pkg::WORD_RESET;
      end
    end else if (armed && store) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        fifo_r[i] <= fifo_r[i+1];
      end
      fifo_r[FIFO_DEPTH-1] <= store_word;
    end else if (fl_read && !armed) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        fifo_r[i] <= fifo_r[i+1];
      end
      fifo_r[FIFO_DEPTH-1] <= last_op_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // break request, a one-cycle pulse in the cycle after run end while bit 4 is set
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      brk_o      <= '0;
    end else begin
      brk_o.req  <= run_done & ctl_r[dbg_trace_pkg::CTL_BREAK_EN_BIT];
      brk_o.tag  <= run_done & ctl_r[dbg_trace_pkg::CTL_BREAK_EN_BIT] &
                    ctl_r[dbg_trace_pkg::CTL_TAG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait cycle then acknowledge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r          <= 1'b0;
      avs_readdata_o <= dbg_trace_pkg::BUS_ZERO;
    end else begin
      ack_r <= bus_req;
      if (rd_go) begin
        unique case (avs_address_i)
          dbg_trace_pkg::CMP_A_HIGH_ADDR: avs_readdata_o <= {24'h0, cmp_a_r[15:8]};
          dbg_trace_pkg::CMP_A_LOW_ADDR:  avs_readdata_o <= {24'h0, cmp_a_r[7:0]};
          dbg_trace_pkg::CMP_B_HIGH_ADDR: avs_readdata_o <= {24'h0, cmp_b_r[15:8]};
          dbg_trace_pkg::CMP_B_LOW_ADDR:  avs_readdata_o <= {24'h0, cmp_b_r[7:0]};
          dbg_trace_pkg::FIFO_HIGH_ADDR:
            avs_readdata_o <= {24'h0, event_only(mode) ? dbg_trace_pkg::BYTE_RESET
                                                       : fifo_r[0][15:8]};
          dbg_trace_pkg::FIFO_LOW_ADDR:   avs_readdata_o <= {24'h0, fifo_r[0][7:0]};
          dbg_trace_pkg::CONTROL_ADDR:    avs_readdata_o <= {24'h0, ctl_r};
          dbg_trace_pkg::TRIG_MODE_ADDR:  avs_readdata_o <= {24'h0, trig_r};
          dbg_trace_pkg::STATUS_ADDR:
            avs_readdata_o <= {24'h0, af_r, bf_r, armed & enabled, 1'b0, cnt_r};
          default:                        avs_readdata_o <= dbg_trace_pkg::BUS_ZERO;
        endcase
      end
    end
  end

  assign avs_waitrequest_o = ~ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_cmp_write_lock: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    armed && avs_write_i && avs_address_i == dbg_trace_pkg::CMP_A_LOW_ADDR
      |=> $stable(cmp_a_r)) else $error("comparator changed while armed");

  a_secure_enable: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    secure_i && !enabled |=> !enabled) else $error("enable set while secure");

  a_fifo_hold_arm: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    fl_read && armed && !store |=> $stable(fifo_r[0])) else $error("fifo moved while armed");

  a_profile_store: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    fl_read && !armed |=> fifo_r[FIFO_DEPTH-1] == $past(last_op_r))
    else $error("profile sample not stored");

  a_fh_no_shift: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rd_go && avs_address_i == dbg_trace_pkg::FIFO_HIGH_ADDR && !armed
      |=> $stable(fifo_r[0])) else $error("high read shifted fifo");

  a_run_disarm: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_done && !wr_go |=> !armed) else $error("run end did not disarm");

  a_break_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    brk_o.req |-> $past(ctl_r[dbg_trace_pkg::CTL_BREAK_EN_BIT]))
    else $error("break without enable");

  a_bus_answer: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    bus_req |=> !avs_waitrequest_o) else $error("bus answer late");

  // bus handshake steps: request taken, then answered
  sequence s_bus_take;
    bus_req ##1 !avs_waitrequest_o;
  endsequence

  a_bus_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_bus_take |=> avs_waitrequest_o) else $error("answer held too long");

  a_cmp_b_lock: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    armed && avs_write_i &&
      (avs_address_i == dbg_trace_pkg::CMP_B_HIGH_ADDR ||
       avs_address_i == dbg_trace_pkg::CMP_B_LOW_ADDR)
      |=> $stable(cmp_b_r)) else $error("comparator b changed while armed");

  a_ctl_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_go && avs_address_i == dbg_trace_pkg::CONTROL_ADDR
      |=> ctl_r[5:0] == $past(avs_writedata_i[5:0]))
    else $error("control write lost");

  a_tag_with_req: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    brk_o.tag |-> brk_o.req) else $error("tag without break request");

  a_end_break: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_done && ctl_r[dbg_trace_pkg::CTL_BREAK_EN_BIT] |=> brk_o.req)
    else $error("break not requested at run end");

  a_break_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !ctl_r[dbg_trace_pkg::CTL_BREAK_EN_BIT] |=> !brk_o.req)
    else $error("break requested while disabled");

  a_fh_event_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rd_go && avs_address_i == dbg_trace_pkg::FIFO_HIGH_ADDR && event_only(mode)
      |=> avs_readdata_o == dbg_trace_pkg::BUS_ZERO)
    else $error("fifo high byte not zero in event mode");

  a_fl_shift: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    fl_read && !armed |=> fifo_r[0] == $past(fifo_r[1]))
    else $error("low read did not advance fifo");

  a_count_limit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cnt_r <= dbg_trace_pkg::FIFO_FULL_COUNT) else $error("valid count overflow");

  a_begin_full: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    armed && begin_tr && store && cnt_r == FIFO_FULL_M1 && !wr_go |=> !armed)
    else $error("full fifo did not end run");

  a_idle_count: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !armed && !arm_write |=> $stable(cnt_r)) else $error("count moved while idle");

  a_dir_a_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ctl_r[dbg_trace_pkg::CTL_A_DIR_QUAL_BIT] &&
      (cpu_i.rd != ctl_r[dbg_trace_pkg::CTL_A_DIR_VAL_BIT]) |-> !match_a)
    else $error("comparator a matched wrong direction");

  a_dir_b_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ctl_r[dbg_trace_pkg::CTL_B_DIR_QUAL_BIT] &&
      (cpu_i.rd != ctl_r[dbg_trace_pkg::CTL_B_DIR_VAL_BIT]) |-> !match_b)
    else $error("comparator b matched wrong direction");

  a_read_upper: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    avs_readdata_o[31:8] == 24'h00_0000) else $error("read data upper bits set");

endmodule // dbg_trace

`default_nettype wire

// ==== cpu_model.sv ====
// cpu bus cycle model facing the debug trace block
`timescale 1ns/1ns
`default_nettype none

module cpu_model (
  // clock
  input  wire logic                     clk_i,
  // observed cpu bus cycle
  output var dbg_trace_pkg::cpu_cycle_t cpu_o
);
  initial cpu_o = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // one valid cycle, then idle with inverted values so stale data never matches
  task automatic cycle(input logic [15:0] a, input logic rd, input logic op);
    begin
      @(posedge clk_i);
      cpu_o <= '{1'b1, a, ~a[7:0], rd, op};
      @(posedge clk_i);
      cpu_o <= '{1'b0, ~a, a[7:0], ~rd, 1'b0};
    end
  endtask
endmodule // cpu_model

`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the debug trace block
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED at %0t: got %0h exp %0h", $time, g, e); end end

module tb_top;
  localparam logic [3:0] CTL  = dbg_trace_pkg::CONTROL_ADDR;
  localparam logic [3:0] STAT = dbg_trace_pkg::STATUS_ADDR;
  localparam logic [3:0] FH   = dbg_trace_pkg::FIFO_HIGH_ADDR;
  localparam logic [3:0] FL   = dbg_trace_pkg::FIFO_LOW_ADDR;

  typedef struct packed {
    logic [3:0]  m;
    logic [7:0]  c;
    logic [15:0] a;
    logic        rd;
    logic        brk;
    logic        tag;
    logic        arm;
  } case_t;

  logic                       clk_i = 1'b0;
  logic                       arst_n_i = 1'b0;
  logic [3:0]                 avs_address_i = 4'h0;
  logic                       avs_read_i = 1'b0;
  logic                       avs_write_i = 1'b0;
  logic [31:0]                avs_writedata_i = 32'h0000_0000;
  logic [3:0]                 avs_byteenable_i = 4'hf;
  logic [31:0]                avs_readdata_o;
  logic                       avs_waitrequest_o;
  dbg_trace_pkg::cpu_cycle_t  cpu_i;
  logic                       secure_i = 1'b0;
  dbg_trace_pkg::break_req_t  brk_o;
  int                         err_count = 0;
  int                         checks = 0;
  int                         brk_cnt = 0;
  int                         n;
  logic                       brk_tag;
  logic [7:0]                 rdat;
  logic [7:0]                 hi;
  logic [15:0]                fq [12];
  case_t                      tbl [9];

  ////////////////////////////////////////////////////////////////////////////////
  // clock, design and cpu model
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  dbg_trace DUT (
    .clk_i             (clk_i),
    .arst_n_i          (arst_n_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .cpu_i             (cpu_i),
    .secure_i          (secure_i),
    .brk_o             (brk_o)
  );

  cpu_model u_cpu (
    .clk_i (clk_i),
    .cpu_o (cpu_i)
  );

  // count break pulses and keep the last type
  always @(posedge clk_i) begin
    if (brk_o.req === 1'b1) begin
      brk_cnt++;
      brk_tag = brk_o.tag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report();
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // one avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    begin
      k = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_read_i <= ~w;
      avs_write_i <= w;
      avs_writedata_i <= {24'h00_0000, d};
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0) begin
        k++;
        if (k > 50) begin
          err_count++;
          $display("CHECK FAILED at %0t: bus timeout", $time);
          final_report();
        end
        @(posedge clk_i);
      end
      rdat = avs_readdata_o[7:0];
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      `CHK(rdat, e)
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    tbl = '{'{4'h0, 8'h30, 16'h1234, 1'b0, 1'b1, 1'b1, 1'b0},
            '{4'h0, 8'h10, 16'h1234, 1'b1, 1'b1, 1'b0, 1'b0},
            '{4'h0, 8'h20, 16'h1234, 1'b0, 1'b0, 1'b0, 1'b0},
            '{4'h0, 8'h1c, 16'h1234, 1'b0, 1'b0, 1'b0, 1'b1},
            '{4'h0, 8'h1c, 16'h1234, 1'b1, 1'b1, 1'b0, 1'b0},
            '{4'h0, 8'h14, 16'h1234, 1'b0, 1'b1, 1'b0, 1'b0},
            '{4'h1, 8'h13, 16'h5678, 1'b0, 1'b0, 1'b0, 1'b1},
            '{4'h1, 8'h13, 16'h5678, 1'b1, 1'b1, 1'b0, 1'b0},
            '{4'h1, 8'h11, 16'h5678, 1'b0, 1'b1, 1'b0, 1'b0}};
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) rd_chk(i[3:0], 8'h00);
    rd_chk(4'hf, 8'h00);
    rd_chk(CTL, 8'h00);
    $display("test reset done");
    bus(1'b1, 4'h0, 8'h12);
    bus(1'b1, 4'h1, 8'h34);
    bus(1'b1, 4'h2, 8'h56);
    bus(1'b1, 4'h3, 8'h78);
    rd_chk(4'h0, 8'h12);
    rd_chk(4'h1, 8'h34);
    rd_chk(4'h2, 8'h56);
    rd_chk(4'h3, 8'h78);
    bus(1'b1, CTL, 8'h0f);
    rd_chk(CTL, 8'h0f);
    secure_i <= 1'b1;
    bus(1'b1, CTL, 8'h80);
    rd_chk(CTL, 8'h00);
    secure_i <= 1'b0;
    bus(1'b1, CTL, 8'h80);
    rd_chk(CTL, 8'h80);
    $display("test registers done");
    // profiling: eight reads primed and discarded, then delayed samples
    bus(1'b1, CTL, 8'h00);
    for (int i = 0; i < 12; i++) begin
      fq[i] = {8'h30 + i[7:0], 8'hc0 - i[7:0]};
      u_cpu.cycle(fq[i], 1'b1, 1'b1);
      bus(1'b1, FH, 8'hff);
      bus(1'b0, FH, 8'h00);
      hi = rdat;
      bus(1'b0, FL, 8'h00);
      if (i >= 8) begin
        `CHK(hi, fq[i-8][15:8])
        `CHK(rdat, fq[i-8][7:0])
      end
    end
    $display("test profiling done");
    bus(1'b1, CTL, 8'hc0);
    bus(1'b0, STAT, 8'h00);
    `CHK(rdat[5], 1'b1)
    bus(1'b1, 4'h1, 8'haa);
    rd_chk(4'h1, 8'h34);
    rd_chk(CTL, 8'hc0);
    bus(1'b1, CTL, 8'h40);
    bus(1'b0, STAT, 8'h00);
    `CHK(rdat[5], 1'b0)
    $display("test arming done");
    // trigger runs: comparator A at 1234, B at 5678, end trace
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, CTL, 8'h80);
      bus(1'b1, dbg_trace_pkg::TRIG_MODE_ADDR, {4'h0, tbl[i].m});
      bus(1'b1, CTL, 8'hc0 | tbl[i].c);
      n = brk_cnt;
      u_cpu.cycle(tbl[i].a, tbl[i].rd, 1'b0);
      repeat (10) @(posedge clk_i);
      `CHK(brk_cnt - n, 32'(tbl[i].brk))
      if (tbl[i].brk) `CHK(brk_tag, tbl[i].tag)
      bus(1'b0, STAT, 8'h00);
      `CHK(rdat[5], tbl[i].arm)
    end
    $display("test breaks done");
    // event-only capture: one byte stored, read back by low reads only
    bus(1'b1, CTL, 8'h80);
    bus(1'b1, dbg_trace_pkg::TRIG_MODE_ADDR, 8'h03);
    bus(1'b1, CTL, 8'hc0);
    u_cpu.cycle(16'h5678, 1'b0, 1'b0);
    bus(1'b1, CTL, 8'h80);
    rd_chk(FH, 8'h00);
    for (int i = 0; i < 7; i++) bus(1'b0, FL, 8'h00);
    rd_chk(FL, 8'h87);
    $display("test event mode done");
    final_report();
  end
endmodule // tb_top

`default_nettype wire
